// ==== hw/sseq_status.sv ====
// status tree, preset, error queue and version answer of the signal generator
`default_nettype none
module sseq_status #(
   parameter longint unsigned WARM_CYCLES = sseq_pkg::SSEQ_WARM_CYC,
   parameter int ERRQ_DEPTH = sseq_pkg::SSEQ_ERRQ_DEPTH,
   parameter int VOLT_W = 16,
   parameter int FREQ_W = 16,
   parameter int CAL_W = 16
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire sseq_pkg::sseq_cmd_t cmd,
   input wire logic err_valid,
   input wire sseq_pkg::sseq_err_t err_in,
   input wire logic [VOLT_W-1:0] volt_fault_pin,
   input wire logic [FREQ_W-1:0] freq_fault_pin,
   input wire logic [CAL_W-1:0] cal_fault_pin,
   input wire logic alc_off_pin,
   input wire logic pcal_off_pin,
   input wire logic am_overmod_pin,
   output logic rsp_valid_ff,
   output sseq_pkg::sseq_rsp_t rsp_ff,
   output logic [7:0] summary_ff,
   output logic [15:0] oper_en_ff,
   output logic [15:0] oper_ptr_ff,
   output logic [15:0] oper_ntr_ff
);
   localparam int NSYNC = VOLT_W + FREQ_W + CAL_W + 3;
   localparam int WCW = 40;
   localparam logic [WCW-1:0] WARM_LAST = WCW'(WARM_CYCLES - 64'h1);

   // ---------------- pin synchronisers ----------------
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   wire logic [NSYNC-1:0] pins_raw;
   wire logic [VOLT_W-1:0] volt_fault;
   wire logic [FREQ_W-1:0] freq_fault;
   wire logic [CAL_W-1:0] cal_fault;
   wire logic alc_off;
   wire logic pcal_off;
   wire logic am_overmod;

   assign pins_raw = {volt_fault_pin, freq_fault_pin, cal_fault_pin,
                      alc_off_pin, pcal_off_pin, am_overmod_pin};
   assign {volt_fault, freq_fault, cal_fault, alc_off, pcal_off, am_overmod} = sync2_ff;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // ---------------- command decode ----------------
   wire logic is_read;
   wire logic is_write;
   wire logic is_preset;
   wire logic is_cls;
   wire logic is_errq;
   wire logic is_errnoq;
   wire logic is_verq;
   wire logic rd_volt;
   wire logic rd_pow;
   wire logic rd_freq;
   wire logic rd_ques;
   wire logic wr_ques_en;
   wire logic wr_oper_en;
   wire logic wr_oper_ptr;
   wire logic wr_oper_ntr;

   assign is_read = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_READ);
   assign is_write = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_WRITE);
   assign is_preset = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_PRESET);
   assign is_cls = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_CLS);
   assign is_errq = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_ERRQ);
   assign is_errnoq = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_ERRNOQ);
   assign is_verq = cmd_valid && (cmd.op == sseq_pkg::SSEQ_OP_VERQ);
   assign rd_volt = is_read && (cmd.sel == sseq_pkg::SSEQ_R_VOLT_EV);
   assign rd_pow = is_read && (cmd.sel == sseq_pkg::SSEQ_R_POW_EV);
   assign rd_freq = is_read && (cmd.sel == sseq_pkg::SSEQ_R_FREQ_EV);
   assign rd_ques = is_read && (cmd.sel == sseq_pkg::SSEQ_R_QUES_EV);
   assign wr_ques_en = is_write && (cmd.sel == sseq_pkg::SSEQ_R_QUES_EN);
   assign wr_oper_en = is_write && (cmd.sel == sseq_pkg::SSEQ_R_OPER_EN);
   assign wr_oper_ptr = is_write && (cmd.sel == sseq_pkg::SSEQ_R_OPER_PTR);
   assign wr_oper_ntr = is_write && (cmd.sel == sseq_pkg::SSEQ_R_OPER_NTR);

   // ---------------- subordinate event registers ----------------
   logic [VOLT_W-1:0] volt_ev;
   logic [FREQ_W-1:0] freq_ev;
   logic [sseq_pkg::SSEQ_POW_W-1:0] pow_ev;
   logic [15:0] ques_ev;
   logic [sseq_pkg::SSEQ_POW_W-1:0] pow_set;

   always_comb begin
      pow_set = '0;
      pow_set[sseq_pkg::SSEQ_PB_ALC] = alc_off;
      pow_set[sseq_pkg::SSEQ_PB_PCAL] = pcal_off;
   end

   sseq_evreg #(.W(VOLT_W)) u_volt_ev (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .set_bits(volt_fault),
      .rd_clr(rd_volt),
      .val_ff(volt_ev)
   );

   sseq_evreg #(.W(FREQ_W)) u_freq_ev (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .set_bits(freq_fault),
      .rd_clr(rd_freq),
      .val_ff(freq_ev)
   );

   sseq_evreg #(.W(sseq_pkg::SSEQ_POW_W)) u_pow_ev (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .set_bits(pow_set),
      .rd_clr(rd_pow),
      .val_ff(pow_ev)
   );

   // ---------------- warm-up timer ----------------
   // counter is wide enough for tens of minutes; the timer stops once done
   logic [WCW-1:0] warm_cnt_ff;
   logic warming_ff;
   logic warm_seen_ff;
   wire logic warm_fall;
   wire logic [WCW-1:0] nxt_warm_cnt;
   wire logic nxt_warming;
   wire logic nxt_warm_seen;

   // the warming condition going false is the implied falling edge
   assign warm_fall = warming_ff && (warm_cnt_ff == WARM_LAST);
   assign nxt_warm_cnt = warming_ff ? warm_cnt_ff + WCW'(1) : warm_cnt_ff;
   assign nxt_warming = warming_ff && !warm_fall;
   // only reset clears this, so a read can never re-arm the warm-up bit
   assign nxt_warm_seen = warm_seen_ff || warm_fall;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         warm_cnt_ff <= '0;
         warming_ff <= 1'b1;
         warm_seen_ff <= 1'b0;
      end else begin
         warm_cnt_ff <= nxt_warm_cnt;
         warming_ff <= nxt_warming;
         warm_seen_ff <= nxt_warm_seen;
      end
   end

   // ---------------- questionable event register ----------------
   // each source is a named wire so the bit map lives in the package alone
   wire logic ques_src_volt;
   wire logic ques_src_pow;
   wire logic ques_src_freq;
   wire logic ques_src_cal;
   wire logic ques_src_am;
   wire logic ques_src_warm;
   logic [15:0] ques_set;

   assign ques_src_volt = |volt_ev;
   assign ques_src_pow = |pow_ev;
   assign ques_src_freq = |freq_ev;
   assign ques_src_cal = |cal_fault;
   assign ques_src_am = am_overmod;
   assign ques_src_warm = warm_fall && !warm_seen_ff;

   always_comb begin
      ques_set = '0;
      ques_set[sseq_pkg::SSEQ_QB_VOLT] = ques_src_volt;
      ques_set[sseq_pkg::SSEQ_QB_POW] = ques_src_pow;
      ques_set[sseq_pkg::SSEQ_QB_FREQ] = ques_src_freq;
      ques_set[sseq_pkg::SSEQ_QB_CAL] = ques_src_cal;
      ques_set[sseq_pkg::SSEQ_QB_AM] = ques_src_am;
      ques_set[sseq_pkg::SSEQ_QB_WARM] = ques_src_warm;
   end

   sseq_evreg #(.W(16)) u_ques_ev (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .set_bits(ques_set & sseq_pkg::SSEQ_QUES_USED),
      .rd_clr(rd_ques),
      .val_ff(ques_ev)
   );

   // ---------------- enables, filters and summary ----------------
   // preset touches only masks and filters; event registers are not wired to it
   logic [15:0] ques_en_ff;
   wire logic [15:0] nxt_ques_en;
   wire logic [15:0] nxt_oper_en;
   wire logic [15:0] nxt_oper_ptr;
   wire logic [15:0] nxt_oper_ntr;
   wire logic ques_hit;

   assign nxt_ques_en = is_preset ? sseq_pkg::SSEQ_ALL_ZERO :
                        wr_ques_en ? (cmd.wdata & sseq_pkg::SSEQ_QUES_USED) : ques_en_ff;
   assign nxt_oper_en = is_preset ? sseq_pkg::SSEQ_ALL_ZERO :
                        wr_oper_en ? cmd.wdata : oper_en_ff;
   assign nxt_oper_ptr = is_preset ? sseq_pkg::SSEQ_ALL_ONE :
                         wr_oper_ptr ? cmd.wdata : oper_ptr_ff;
   assign nxt_oper_ntr = is_preset ? sseq_pkg::SSEQ_ALL_ZERO :
                         wr_oper_ntr ? cmd.wdata : oper_ntr_ff;
   assign ques_hit = |(ques_ev & ques_en_ff);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ques_en_ff <= sseq_pkg::SSEQ_QUES_EN_RST;
         oper_en_ff <= sseq_pkg::SSEQ_ALL_ZERO;
         oper_ptr_ff <= sseq_pkg::SSEQ_ALL_ONE;
         oper_ntr_ff <= sseq_pkg::SSEQ_ALL_ZERO;
         summary_ff <= '0;
      end else begin
         ques_en_ff <= nxt_ques_en;
         oper_en_ff <= nxt_oper_en;
         oper_ptr_ff <= nxt_oper_ptr;
         oper_ntr_ff <= nxt_oper_ntr;
         summary_ff <= 8'(ques_hit) << sseq_pkg::SSEQ_SUM_QUES;
      end
   end

   // ---------------- error queue ----------------
   // a -113 that collides with an external error waits one free cycle
   logic hdr_pend_ff;
   wire logic hdr_req;
   wire logic q_push;
   wire sseq_pkg::sseq_err_t q_d;
   wire sseq_pkg::sseq_err_t q_head;
   wire logic q_empty;
   wire sseq_pkg::sseq_err_t hdr_err;

   assign hdr_req = is_errnoq || hdr_pend_ff;
   assign hdr_err = '{code: sseq_pkg::SSEQ_E_UNDEF_HDR, desc: sseq_pkg::SSEQ_D_UNDEF_HDR};
   assign q_push = (err_valid || hdr_req) && !is_cls;
   assign q_d = err_valid ? err_in : hdr_err;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hdr_pend_ff <= 1'b0;
      end else begin
         hdr_pend_ff <= hdr_req && err_valid && !is_cls;
      end
   end

   sseq_errq #(.DEPTH(ERRQ_DEPTH)) u_errq (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .push(q_push),
      .push_d(q_d),
      .pop(is_errq),
      .flush(is_cls),
      .head(q_head),
      .empty(q_empty)
   );

   // ---------------- answer mux ----------------
   // one select wire per register keeps the read path a flat and-or;
   // a selector with no register behind it matches nothing and reads zero
   wire logic sel_volt;
   wire logic sel_pow;
   wire logic sel_freq;
   wire logic sel_cal;
   wire logic sel_ques_en;
   wire logic sel_ques_ev;
   wire logic sel_oper_en;
   wire logic sel_oper_ptr;
   wire logic sel_oper_ntr;
   wire logic sel_summary;
   wire logic [15:0] volt_word;
   wire logic [15:0] pow_word;
   wire logic [15:0] freq_word;
   wire logic [15:0] cal_word;
   wire logic [15:0] summary_word;
   wire logic [15:0] rd_word;
   wire logic [15:0] errq_word;
   wire logic [4:0] errq_desc;
   wire sseq_pkg::sseq_rsp_t rd_rsp;
   wire sseq_pkg::sseq_rsp_t errq_rsp;
   wire sseq_pkg::sseq_rsp_t ver_rsp;
   wire sseq_pkg::sseq_rsp_t nxt_rsp;

   assign sel_volt = (cmd.sel == sseq_pkg::SSEQ_R_VOLT_EV);
   assign sel_pow = (cmd.sel == sseq_pkg::SSEQ_R_POW_EV);
   assign sel_freq = (cmd.sel == sseq_pkg::SSEQ_R_FREQ_EV);
   assign sel_cal = (cmd.sel == sseq_pkg::SSEQ_R_CAL_COND);
   assign sel_ques_en = (cmd.sel == sseq_pkg::SSEQ_R_QUES_EN);
   assign sel_ques_ev = (cmd.sel == sseq_pkg::SSEQ_R_QUES_EV);
   assign sel_oper_en = (cmd.sel == sseq_pkg::SSEQ_R_OPER_EN);
   assign sel_oper_ptr = (cmd.sel == sseq_pkg::SSEQ_R_OPER_PTR);
   assign sel_oper_ntr = (cmd.sel == sseq_pkg::SSEQ_R_OPER_NTR);
   assign sel_summary = (cmd.sel == sseq_pkg::SSEQ_R_SUMMARY);
   // narrower registers are widened with zeros, so their unused bits read zero
   assign volt_word = 16'(volt_ev);
   assign pow_word = 16'(pow_ev);
   assign freq_word = 16'(freq_ev);
   assign cal_word = 16'(cal_fault);
   assign summary_word = 16'(summary_ff);
   assign rd_word = ({16{sel_volt}} & volt_word)
      | ({16{sel_pow}} & pow_word)
      | ({16{sel_freq}} & freq_word)
      | ({16{sel_cal}} & cal_word)
      | ({16{sel_ques_en}} & ques_en_ff)
      | ({16{sel_ques_ev}} & ques_ev)
      | ({16{sel_oper_en}} & oper_en_ff)
      | ({16{sel_oper_ptr}} & oper_ptr_ff)
      | ({16{sel_oper_ntr}} & oper_ntr_ff)
      | ({16{sel_summary}} & summary_word);
   assign errq_word = q_empty ? sseq_pkg::SSEQ_E_NONE : q_head.code;
   assign errq_desc = q_empty ? sseq_pkg::SSEQ_D_NONE : q_head.desc;
   assign rd_rsp = '{data: rd_word, desc: sseq_pkg::SSEQ_D_NONE};
   assign errq_rsp = '{data: errq_word, desc: errq_desc};
   assign ver_rsp = '{data: sseq_pkg::SSEQ_VER_YEAR, desc: sseq_pkg::SSEQ_VER_REV};
   assign nxt_rsp = is_read ? rd_rsp :
                    is_errq ? errq_rsp :
                    is_verq ? ver_rsp : '0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rsp_valid_ff <= 1'b0;
         rsp_ff <= '0;
      end else begin
         rsp_valid_ff <= is_read || is_errq || is_verq;
         rsp_ff <= nxt_rsp;
      end
   end
endmodule // sseq_status
`default_nettype wire

// ==== shared/sseq_pkg.sv ====
// package: constants and carriers for the status tree and error queue
`default_nettype none
package sseq_pkg;
   // command opcodes arriving from the command parser
   typedef enum logic [2:0] {
      SSEQ_OP_READ = 3'h0,
      SSEQ_OP_WRITE = 3'h1,
      SSEQ_OP_PRESET = 3'h2,
      SSEQ_OP_CLS = 3'h3,
      SSEQ_OP_ERRQ = 3'h4,
      SSEQ_OP_ERRNOQ = 3'h5,
      SSEQ_OP_VERQ = 3'h6
   } sseq_op_t;

   // register selectors
   typedef enum logic [3:0] {
      SSEQ_R_VOLT_EV = 4'h0,
      SSEQ_R_POW_EV = 4'h1,
      SSEQ_R_FREQ_EV = 4'h2,
      SSEQ_R_CAL_COND = 4'h3,
      SSEQ_R_QUES_EN = 4'h4,
      SSEQ_R_QUES_EV = 4'h5,
      SSEQ_R_OPER_EN = 4'h6,
      SSEQ_R_OPER_PTR = 4'h7,
      SSEQ_R_OPER_NTR = 4'h8,
      SSEQ_R_SUMMARY = 4'h9
   } sseq_reg_t;

   typedef struct packed {
      sseq_op_t op;
      sseq_reg_t sel;
      logic [15:0] wdata;
   } sseq_cmd_t;

   typedef struct packed {
      logic signed [15:0] code;
      logic [4:0] desc;
   } sseq_err_t;

   typedef struct packed {
      logic [15:0] data;
      logic [4:0] desc;
   } sseq_rsp_t;

   // questionable event bit positions
   localparam int SSEQ_QB_VOLT = 0;
   localparam int SSEQ_QB_POW = 3;
   localparam int SSEQ_QB_FREQ = 5;
   localparam int SSEQ_QB_CAL = 7;
   localparam int SSEQ_QB_AM = 8;
   localparam int SSEQ_QB_WARM = 10;
   localparam logic [15:0] SSEQ_QUES_USED = 16'h05A9;
   localparam logic [15:0] SSEQ_QUES_EN_RST = 16'h0001;
   localparam int SSEQ_SUM_QUES = 3;

   // power event bit positions, register is eight bits wide
   localparam int SSEQ_PB_ALC = 0;
   localparam int SSEQ_PB_PCAL = 1;
   localparam int SSEQ_POW_W = 8;

   localparam logic [15:0] SSEQ_ALL_ZERO = 16'h0000;
   localparam logic [15:0] SSEQ_ALL_ONE = 16'hFFFF;

   // error codes and their description indexes
   localparam logic signed [15:0] SSEQ_E_NONE = 16'sh0000;
   localparam logic signed [15:0] SSEQ_E_UNDEF_HDR = -16'sh0071;
   localparam logic signed [15:0] SSEQ_E_BAD_SUFFIX = -16'sh0083;
   localparam logic signed [15:0] SSEQ_E_RANGE = -16'sh00DE;
   localparam logic signed [15:0] SSEQ_E_OVERFLOW = -16'sh015E;
   localparam logic [4:0] SSEQ_D_NONE = 5'h00;
   localparam logic [4:0] SSEQ_D_UNDEF_HDR = 5'h04;
   localparam logic [4:0] SSEQ_D_BAD_SUFFIX = 5'h06;
   localparam logic [4:0] SSEQ_D_RANGE = 5'h0F;
   localparam logic [4:0] SSEQ_D_OVERFLOW = 5'h15;

   // version answer: year in data, revision in desc
   localparam logic [15:0] SSEQ_VER_YEAR = 16'h07C9;
   localparam logic [4:0] SSEQ_VER_REV = 5'h00;

   // warm-up time
   localparam longint unsigned SSEQ_WARM_MIN = 64'h0000_0000_0000_000F;
   localparam longint unsigned SSEQ_CLK_HZ = 64'h0000_0000_017D_7840;
   localparam longint unsigned SSEQ_WARM_CYC = SSEQ_WARM_MIN * 64'h3C * SSEQ_CLK_HZ;

   localparam int SSEQ_ERRQ_DEPTH = 8;
endpackage
`default_nettype wire

// ==== hw/sseq_evreg.sv ====
// latched event register, cleared by a read, a set in the read cycle wins
`default_nettype none
module sseq_evreg #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [W-1:0] set_bits,
   input wire logic rd_clr,
   output logic [W-1:0] val_ff
);
   wire logic [W-1:0] nxt_val;

   assign nxt_val = (rd_clr ? '0 : val_ff) | set_bits;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         val_ff <= '0;
      end else begin
         val_ff <= nxt_val;
      end
   end
endmodule // sseq_evreg
`default_nettype wire

// ==== hw/sseq_errq.sv ====
// first-in first-out error queue with overflow marking
`default_nettype none
module sseq_errq #(
   parameter int DEPTH = sseq_pkg::SSEQ_ERRQ_DEPTH
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic push,
   input wire sseq_pkg::sseq_err_t push_d,
   input wire logic pop,
   input wire logic flush,
   output sseq_pkg::sseq_err_t head,
   output logic empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULLCNT = (AW + 1)'(DEPTH);

   sseq_pkg::sseq_err_t mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] cnt_ff;
   wire logic full;
   wire logic do_pop;
   wire logic do_push;
   wire logic do_ovf;
   wire logic [AW-1:0] wr_nxt;
   wire logic [AW-1:0] rd_nxt;
   wire logic [AW-1:0] newest;
   wire sseq_pkg::sseq_err_t ovf_entry;

   assign full = (cnt_ff == FULLCNT);
   assign empty = (cnt_ff == '0);
   assign do_pop = pop && !empty;
   // a pop in the same cycle frees a slot, so the push goes in normally
   assign do_push = push && (!full || do_pop);
   assign do_ovf = push && full && !do_pop;
   assign wr_nxt = (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + AW'(1);
   assign rd_nxt = (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + AW'(1);
   assign newest = (wr_ptr_ff == '0) ? LAST : wr_ptr_ff - AW'(1);
   assign ovf_entry = '{code: sseq_pkg::SSEQ_E_OVERFLOW, desc: sseq_pkg::SSEQ_D_OVERFLOW};
   assign head = mem[rd_ptr_ff];

   // storage carries no reset; cnt guards every read of it
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[wr_ptr_ff] <= push_d;
      end else if (do_ovf) begin
         mem[newest] <= ovf_entry;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else if (flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ptr_ff <= do_push ? wr_nxt : wr_ptr_ff;
         rd_ptr_ff <= do_pop ? rd_nxt : rd_ptr_ff;
         cnt_ff <= cnt_ff + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
   end
endmodule // sseq_errq
`default_nettype wire

// ==== tb/sseq_status_sva.sv ====
// assertion checker on the status block ports
`default_nettype none
module sseq_status_sva #(
   parameter int CAL_W = 16
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire sseq_pkg::sseq_cmd_t cmd,
   input wire logic [CAL_W-1:0] cal_fault_pin,
   input wire logic rsp_valid_ff,
   input wire sseq_pkg::sseq_rsp_t rsp_ff,
   input wire logic [7:0] summary_ff,
   input wire logic [15:0] oper_en_ff,
   input wire logic [15:0] oper_ptr_ff,
   input wire logic [15:0] oper_ntr_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire logic rd = cmd_valid && cmd.op == sseq_pkg::SSEQ_OP_READ;
   wire logic pre = cmd_valid && cmd.op == sseq_pkg::SSEQ_OP_PRESET;
   wire logic en_wr = cmd_valid && cmd.op == sseq_pkg::SSEQ_OP_WRITE
      && cmd.sel == sseq_pkg::SSEQ_R_QUES_EN;
   sequence s_preset;
      pre;
   endsequence
   sequence s_no_en_write;
      !en_wr;
   endsequence
   preset_filters_a: assert property (
      s_preset |=> oper_en_ff == 16'h0000 && oper_ntr_ff == 16'h0000 && oper_ptr_ff == 16'hFFFF)
      else $error("preset left operational masks wrong");
   // summary follows the cleared mask two edges later
   preset_summary_a: assert property (
      s_preset ##1 s_no_en_write |=> ##1 !summary_ff[3])
      else $error("summary bit stayed set after preset");
   version_reply_a: assert property (
      cmd_valid && cmd.op == sseq_pkg::SSEQ_OP_VERQ |=> rsp_valid_ff
      && rsp_ff.data == 16'h07C9 && rsp_ff.desc == 5'h00)
      else $error("version answer wrong");
   summary_unused_a: assert property (
      summary_ff[7:4] == 4'h0 && summary_ff[2:0] == 3'h0)
      else $error("unused summary bit set");
   pow_unused_a: assert property (
      rd && cmd.sel == sseq_pkg::SSEQ_R_POW_EV |=> rsp_ff.data[15:2] == 14'h0000)
      else $error("unused power bit read set");
   ques_unused_a: assert property (
      rd && cmd.sel inside {sseq_pkg::SSEQ_R_QUES_EN, sseq_pkg::SSEQ_R_QUES_EV}
      |=> (rsp_ff.data & 16'hFA56) == 16'h0000)
      else $error("unused questionable bit read set");
   enable_read_a: assert property (
      rd && cmd.sel == sseq_pkg::SSEQ_R_OPER_EN |=> rsp_ff.data == $past(oper_en_ff)
      && $stable(oper_en_ff))
      else $error("enable read wrong or disturbed");
   cal_live_a: assert property (
      $stable(cal_fault_pin)[*5] ##0 rd && cmd.sel == sseq_pkg::SSEQ_R_CAL_COND
      |=> rsp_ff.data[CAL_W-1:0] == $past(cal_fault_pin))
      else $error("calibration condition read wrong");
endmodule // sseq_status_sva
bind sseq_status sseq_status_sva #(.CAL_W(CAL_W)) u_sva (.clk_sys(clk_sys), .resetn(resetn),
   .cmd_valid(cmd_valid), .cmd(cmd), .cal_fault_pin(cal_fault_pin),
   .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff), .summary_ff(summary_ff),
   .oper_en_ff(oper_en_ff), .oper_ptr_ff(oper_ptr_ff), .oper_ntr_ff(oper_ntr_ff));
`default_nettype wire

// ==== tb/sseq_host.sv ====
// host model: issues one command at a time and collects the answer
`default_nettype none
module sseq_host (
   input wire logic clk_sys,
   output logic cmd_valid,
   output sseq_pkg::sseq_cmd_t cmd,
   input wire logic rsp_valid_ff,
   input wire sseq_pkg::sseq_rsp_t rsp_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // idle word is inverted so a stale command can never look valid
   task automatic xfer(input logic [2:0] op, input logic [3:0] s, input logic [15:0] wd,
      output sseq_pkg::sseq_rsp_t rsp);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd = {op, s, wd};
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd = ~cmd;
      rsp = rsp_valid_ff ? rsp_ff : 'x;
   endtask
endmodule // sseq_host
`default_nettype wire

// ==== tb/sseq_status_bench.sv ====
// self-checking bench for the status tree and error queue
`default_nettype none
module sseq_status_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, resetn, cmd_valid, err_valid, alc, pcal, am, rsp_valid_ff;
   logic [15:0] volt, freq, cal, oper_en, oper_ptr, oper_ntr;
   logic [7:0] summary_ff;
   sseq_pkg::sseq_cmd_t cmd;
   sseq_pkg::sseq_err_t err_in;
   sseq_pkg::sseq_rsp_t rsp_ff, seen;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // short warm-up and queue so both limits are reached in a short run
   sseq_status #(.WARM_CYCLES(64'h0000_0000_0000_0BB8), .ERRQ_DEPTH(4)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
      .err_valid(err_valid), .err_in(err_in), .volt_fault_pin(volt), .freq_fault_pin(freq),
      .cal_fault_pin(cal), .alc_off_pin(alc), .pcal_off_pin(pcal), .am_overmod_pin(am),
      .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff), .summary_ff(summary_ff),
      .oper_en_ff(oper_en), .oper_ptr_ff(oper_ptr), .oper_ntr_ff(oper_ntr));
   sseq_host u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // op codes: 0 read 1 write 2 preset 3 clear 4 error query 5 bad query 6 version
   task automatic go(input logic [2:0] op, input logic [3:0] s, input logic [15:0] wd);
      u_host.xfer(op, s, wd, seen);
   endtask
   task automatic rd(input logic [3:0] s, input logic [15:0] exp);
      go(3'h0, s, 16'h0000);
      chk($sformatf("register %0d", s), exp, seen.data);
   endtask
   task automatic chk_err(input logic [15:0] code, input logic [4:0] desc);
      go(3'h4, 4'h0, 16'h0000);
      chk("error code", code, seen.data);
      chk("error text", {11'h000, desc}, {11'h000, seen.desc});
   endtask
   task automatic push(input logic [15:0] code, input logic [4:0] desc);
      @(negedge clk_sys);
      err_valid = 1'b1;
      err_in = {code, desc};
      @(negedge clk_sys);
      err_valid = 1'b0;
      err_in = ~err_in;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   initial begin
      resetn = 1'b0;
      err_valid = 1'b0;
      err_in = '0;
      {volt, freq, cal, alc, pcal, am} = '0;
      idle(6);
      resetn = 1'b1;
      rd(4'h4, 16'h0001);
      chk("oper ptr", 16'hFFFF, oper_ptr);
      $display("reset test done");
      volt = 16'hA005;
      freq = 16'h0300;
      cal = 16'h0003;
      alc = 1'b1;
      idle(8);
      {volt, freq, alc} = '0;
      idle(4);
      rd(4'h3, 16'h0003);
      rd(4'h3, 16'h0003);
      cal = 16'h0000;
      idle(6);
      rd(4'h3, 16'h0000);
      rd(4'h0, 16'hA005);
      rd(4'h0, 16'h0000);
      rd(4'h2, 16'h0300);
      rd(4'h1, 16'h0001);
      pcal = 1'b1;
      idle(4);
      pcal = 1'b0;
      idle(4);
      rd(4'h1, 16'h0002);
      rd(4'h1, 16'h0000);
      chk("summary", 16'h0008, {8'h00, summary_ff});
      rd(4'h5, 16'h00A9);
      rd(4'h5, 16'h0000);
      idle(3);
      chk("summary", 16'h0000, {8'h00, summary_ff});
      $display("event test done");
      am = 1'b1;
      freq = 16'h0010;
      idle(6);
      {am, freq} = '0;
      idle(4);
      go(3'h1, 4'h4, 16'hFFFF);
      rd(4'h4, 16'h05A9);
      rd(4'h4, 16'h05A9);
      idle(2);
      chk("summary", 16'h0008, {8'h00, summary_ff});
      go(3'h1, 4'h6, 16'h1001);
      go(3'h1, 4'h7, 16'h1000);
      go(3'h1, 4'h8, 16'h0001);
      rd(4'h6, 16'h1001);
      rd(4'h6, 16'h1001);
      go(3'h2, 4'h0, 16'h0000);
      rd(4'h4, 16'h0000);
      chk("oper enable", 16'h0000, oper_en);
      chk("oper rising", 16'hFFFF, oper_ptr);
      chk("oper falling", 16'h0000, oper_ntr);
      chk("summary", 16'h0000, {8'h00, summary_ff});
      rd(4'h2, 16'h0010);
      rd(4'h5, 16'h0120);
      rd(4'h5, 16'h0000);
      $display("mask test done");
      chk_err(16'h0000, 5'h00);
      push(16'hFF7D, 5'h06);
      push(16'hFF22, 5'h0F);
      go(3'h5, 4'h0, 16'h0000);
      chk_err(16'hFF7D, 5'h06);
      chk_err(16'hFF22, 5'h0F);
      chk_err(16'hFF8F, 5'h04);
      chk_err(16'h0000, 5'h00);
      for (int i = 1; i <= 5; i++) push(16'hFF9C - 16'(i), 5'(i));
      for (int i = 1; i <= 3; i++) chk_err(16'hFF9C - 16'(i), 5'(i));
      chk_err(16'hFEA2, 5'h15);
      chk_err(16'h0000, 5'h00);
      push(16'hFF9B, 5'h01);
      go(3'h3, 4'h0, 16'h0000);
      chk_err(16'h0000, 5'h00);
      go(3'h6, 4'h0, 16'h0000);
      chk("version", 16'h07C9, seen.data);
      $display("queue test done");
      while (cycles < 3100) idle(1);
      rd(4'h5, 16'h0400);
      rd(4'h5, 16'h0000);
      idle(50);
      rd(4'h5, 16'h0000);
      $display("warm-up test done");
      stop_test();
   end
endmodule // sseq_status_bench
`default_nettype wire
